// >>> rtl/i2c_intr_defines.svh
// Offsets, field positions, reset values and sizes of the
// I2C interrupt status block. Included by the package and by the RTL.
`ifndef I2C_INTR_DEFINES_SVH
`define I2C_INTR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ADDR_MASKED_STAT   32'h5000132c
`define ADDR_INTR_MASK     32'h50001330
`define ADDR_RAW_STAT      32'h50001334
`define ADDR_DATA_CMD      32'h50001310
`define ADDR_CTRL_ENABLE   32'h5000136c
`define ADDR_TX_THRESH     32'h5000133c
`define ADDR_RX_THRESH     32'h50001338
`define ADDR_CLR_ALL       32'h50001340
`define ADDR_CLR_RX_UNDER  32'h50001344
`define ADDR_CLR_RX_OVER   32'h50001348
`define ADDR_CLR_TX_OVER   32'h5000134c
`define ADDR_CLR_RD_REQ    32'h50001350
`define ADDR_CLR_TX_ABORT  32'h50001354
`define ADDR_CLR_TX_DONE   32'h50001358
`define ADDR_CLR_ACTIVITY  32'h5000135c
`define ADDR_CLR_STOP      32'h50001360
`define ADDR_CLR_START     32'h50001364
`define ADDR_ABORT_CAUSE   32'h50001380
`define ADDR_STATUS        32'h50001370

// ----------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------
`define BIT_START     10
`define BIT_STOP      9
`define BIT_ACTIVITY  8
`define BIT_TX_DONE   7
`define BIT_TX_ABORT  6
`define BIT_RD_REQ    5
`define BIT_TX_EMPTY  4
`define BIT_TX_OVER   3
`define BIT_RX_FULL   2
`define BIT_RX_OVER   1
`define BIT_RX_UNDER  0
`define BIT_ENABLE    0

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define RST_INTR_MASK  16'h08ff
`define RST_THRESH     8'h00
`define FIFO_DEPTH     32
`define STAT_BITS      11
`define SYNC_STAGES    2

`endif

// >>> rtl/i2c_intr_pkg.sv
// Types shared by the I2C interrupt status block.
// Assumes the defines header sits beside it in rtl/.
`include "i2c_intr_defines.svh"

package i2c_intr_pkg;

   // Register data word
   typedef logic [15:0] reg_word_t;

   // Internal enable: off, running, or draining after a disable
   typedef enum logic [1:0] {EN_OFF, EN_ON, EN_DRAIN} en_state_e;

endpackage

// >>> rtl/bus_evt_if.sv
// Bus condition events passed from the line watcher to the status logic.
// Assumes a single core clock domain on both ends.
`timescale 1ns/1ps

interface bus_evt_if;
   logic start_seen;
   logic stop_seen;
   logic scl_level;

   modport src (output start_seen, output stop_seen, output scl_level);
   modport dst (input start_seen, input stop_seen, input scl_level);
endinterface

// >>> rtl/i2c_line_watch.sv
// Samples the bus lines into the core clock and flags START and STOP.
// Assumes the lines change far slower than the 20 ns core clock.
`timescale 1ns/1ps

module i2c_line_watch
   import i2c_intr_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Bus lines
   input wire logic i_scl,
   input wire logic i_sda,
   // Events
   bus_evt_if.src evt
);

   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_prev_q;
   logic sda_prev_q;
   logic start_q;
   logic stop_q;
   wire scl_s = scl_sync_q[1];
   wire sda_s = sda_sync_q[1];
   // Data moving while clock stays high marks a bus condition
   wire start_d = scl_s && scl_prev_q && sda_prev_q && !sda_s;
   wire stop_d = scl_s && scl_prev_q && !sda_prev_q && sda_s;

   // ----------------------------------------------------------------------
   // Two-stage synchronisers; only the second stage is looked at
   // ----------------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         start_q <= 1'b0;
         stop_q <= 1'b0;
      end
      else
      begin
         scl_sync_q <= {scl_sync_q[0], i_scl};
         sda_sync_q <= {sda_sync_q[0], i_sda};
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         start_q <= start_d;
         stop_q <= stop_d;
      end
   end

   assign evt.start_seen = start_q;
   assign evt.stop_seen = stop_q;
   assign evt.scl_level = scl_prev_q;

endmodule

// >>> rtl/i2c_interrupt_status_logic.sv
// I2C interrupt status logic: sticky and level status, FIFOs, mask, irq.
// Assumes a protocol engine on the same clock supplies event pulses and
// an activity level, and that the bus lines arrive asynchronously.
`timescale 1ns/1ps
`include "i2c_intr_defines.svh"

module i2c_interrupt_status_logic
   import i2c_intr_pkg::*;
#(
   parameter int DEPTH = `FIFO_DEPTH,
   parameter int AW = $clog2(DEPTH)
)
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Register port
   input wire logic i_reg_sel,
   input wire logic i_reg_write,
   input wire logic [31:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // Bus lines
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_scl_out,
   output logic o_scl_oe_n,
   // Protocol engine side
   input wire logic i_engine_active,
   input wire logic i_slv_tx_nack,
   input wire logic i_tx_abort_evt,
   input wire logic [15:0] i_abort_cause,
   input wire logic i_rd_req_evt,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_byte,
   input wire logic i_tx_pop,
   output logic [8:0] o_tx_head,
   output logic o_tx_avail,
   output logic o_ctrl_enable,
   // Interrupt
   output logic o_irq
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [8:0] tx_mem [DEPTH];
   logic [7:0] rx_mem [DEPTH];
   logic [AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
   logic [AW:0] tx_cnt_q, rx_cnt_q;
   logic [`STAT_BITS-1:0] raw_q;
   reg_word_t mask_q;
   reg_word_t cause_q;
   logic [7:0] tx_tl_q, rx_threshold_field_q;
   logic en_q;
   en_state_e en_st_q;
   logic [15:0] rdata_q;
   logic rvalid_q;
   logic irq_q;
   logic [8:0] tx_head_q;
   logic scl_oe_n_q;
   logic tx_avail_q;

   bus_evt_if evt ();

   i2c_line_watch u_watch (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .evt(evt)
   );

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
      hit = (a == off);
   endfunction

   wire rd = i_reg_sel && !i_reg_write;
   wire wr = i_reg_sel && i_reg_write;
   wire rd_clr_all = rd && hit(i_reg_addr, `ADDR_CLR_ALL);
   wire rd_data = rd && hit(i_reg_addr, `ADDR_DATA_CMD);
   wire wr_data = wr && hit(i_reg_addr, `ADDR_DATA_CMD);
   wire wr_en = wr && hit(i_reg_addr, `ADDR_CTRL_ENABLE);
   wire wr_mask = wr && hit(i_reg_addr, `ADDR_INTR_MASK);
   wire wr_tx_tl = wr && hit(i_reg_addr, `ADDR_TX_THRESH);
   wire wr_rx_threshold_field = wr && hit(i_reg_addr, `ADDR_RX_THRESH);

   // Per-bit clear strobes from reads of the clear registers
   logic [`STAT_BITS-1:0] rd_clr;
   assign rd_clr[`BIT_START] = rd && hit(i_reg_addr, `ADDR_CLR_START);
   assign rd_clr[`BIT_STOP] = rd && hit(i_reg_addr, `ADDR_CLR_STOP);
   assign rd_clr[`BIT_ACTIVITY] = rd && hit(i_reg_addr, `ADDR_CLR_ACTIVITY);
   assign rd_clr[`BIT_TX_DONE] = rd && hit(i_reg_addr, `ADDR_CLR_TX_DONE);
   assign rd_clr[`BIT_TX_ABORT] = rd && hit(i_reg_addr, `ADDR_CLR_TX_ABORT);
   assign rd_clr[`BIT_RD_REQ] = rd && hit(i_reg_addr, `ADDR_CLR_RD_REQ);
   assign rd_clr[`BIT_TX_EMPTY] = 1'b0;
   assign rd_clr[`BIT_TX_OVER] = rd && hit(i_reg_addr, `ADDR_CLR_TX_OVER);
   assign rd_clr[`BIT_RX_FULL] = 1'b0;
   assign rd_clr[`BIT_RX_OVER] = rd && hit(i_reg_addr, `ADDR_CLR_RX_OVER);
   assign rd_clr[`BIT_RX_UNDER] = rd && hit(i_reg_addr, `ADDR_CLR_RX_UNDER);

   // ----------------------------------------------------------------------
   // Internal enable and FIFO conditions
   // ----------------------------------------------------------------------
   // Internal enable stays high after a disable until the engine idles
   wire internal_enable_signal = (en_st_q != EN_OFF);
   wire abort_set = raw_q[`BIT_TX_ABORT];
   wire tx_flush = !en_q || abort_set;
   wire rx_flush = !en_q;
   wire tx_full = (tx_cnt_q == (AW+1)'(DEPTH));
   wire rx_full = (rx_cnt_q == (AW+1)'(DEPTH));
   wire rx_empty = (rx_cnt_q == '0);
   wire tx_push = wr_data && !tx_flush && !tx_full;
   wire tx_pull = i_tx_pop && !tx_flush && (tx_cnt_q != '0);
   wire rx_push = i_rx_valid && !rx_flush && !rx_full;
   wire rx_pull = rd_data && !rx_flush && !rx_empty;

   // Level flags
   wire tx_empty_lvl = internal_enable_signal && en_q ? (tx_cnt_q <= {1'b0, tx_tl_q[AW-1:0]})
                                     : i_engine_active;
   wire rx_full_lvl = en_q && (rx_cnt_q >= {1'b0, rx_threshold_field_q[AW-1:0]});

   // Sticky set events
   logic [`STAT_BITS-1:0] set_evt;
   assign set_evt[`BIT_START] = evt.start_seen;
   assign set_evt[`BIT_STOP] = evt.stop_seen;
   assign set_evt[`BIT_ACTIVITY] = en_q && (i_engine_active || evt.start_seen);
   assign set_evt[`BIT_TX_DONE] = i_slv_tx_nack;
   assign set_evt[`BIT_TX_ABORT] = i_tx_abort_evt;
   assign set_evt[`BIT_RD_REQ] = i_rd_req_evt;
   assign set_evt[`BIT_TX_EMPTY] = 1'b0;
   assign set_evt[`BIT_TX_OVER] = wr_data && tx_full && en_q;
   assign set_evt[`BIT_RX_FULL] = 1'b0;
   assign set_evt[`BIT_RX_OVER] = i_rx_valid && rx_full && en_q;
   assign set_evt[`BIT_RX_UNDER] = rd_data && rx_empty && en_q;

   // Sticky clear terms; activity clears on the enable bit itself
   logic [`STAT_BITS-1:0] clr_evt;
   assign clr_evt = rd_clr | {`STAT_BITS{rd_clr_all}} | {`STAT_BITS{!internal_enable_signal}};
   wire act_clr = rd_clr[`BIT_ACTIVITY] || rd_clr_all || !en_q;

   // Next raw status: set wins over clear, level bits follow the FIFOs, but the transmit empty bit follows i_engine_active unless enabled
   logic [`STAT_BITS-1:0] raw_d;
   genvar g;
   generate
      for (g = 0; g < `STAT_BITS; g++)
      begin : g_stat
         if (g == `BIT_TX_EMPTY)
         begin : g_txe
            assign raw_d[g] = tx_empty_lvl;
         end
         else if (g == `BIT_RX_FULL)
         begin : g_rxf
            assign raw_d[g] = rx_full_lvl;
         end
         else if (g == `BIT_ACTIVITY)
         begin : g_act
            assign raw_d[g] = set_evt[g] || (raw_q[g] && !act_clr);
         end
         else
         begin : g_stk
            assign raw_d[g] = set_evt[g] || (raw_q[g] && !clr_evt[g]);
         end
      end
   endgenerate

   // Masked view of the status
   wire [15:0] raw_word = {{(16-`STAT_BITS){1'b0}}, raw_q};
   wire [15:0] masked_word = raw_word & mask_q;

   // Read data selection
   logic [15:0] rdata_d;
   always_comb
   begin
      rdata_d = 16'h0000;
      if (rd && hit(i_reg_addr, `ADDR_MASKED_STAT))
         rdata_d = masked_word;
      else if (rd && hit(i_reg_addr, `ADDR_RAW_STAT))
         rdata_d = raw_word;
      else if (rd && hit(i_reg_addr, `ADDR_INTR_MASK))
         rdata_d = mask_q;
      else if (rd && hit(i_reg_addr, `ADDR_ABORT_CAUSE))
         rdata_d = cause_q;
      else if (rd && hit(i_reg_addr, `ADDR_CTRL_ENABLE))
         rdata_d = {15'h0000, en_q};
      else if (rd && hit(i_reg_addr, `ADDR_TX_THRESH))
         rdata_d = {8'h00, tx_tl_q};
      else if (rd && hit(i_reg_addr, `ADDR_RX_THRESH))
         rdata_d = {8'h00, rx_threshold_field_q};
      else if (rd && hit(i_reg_addr, `ADDR_STATUS))
         rdata_d = {14'h0000, i_engine_active, internal_enable_signal};
      else if (rx_pull)
         rdata_d = {8'h00, rx_mem[rx_rp_q]};
   end

   // ----------------------------------------------------------------------
   // Internal enable sequencing
   // ----------------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         en_st_q <= EN_OFF;
      else
      begin
         case (en_st_q)
            EN_OFF: if (en_q) en_st_q <= EN_ON;
            EN_ON: if (!en_q) en_st_q <= i_engine_active ? EN_DRAIN : EN_OFF;
            EN_DRAIN: if (!i_engine_active) en_st_q <= en_q ? EN_ON : EN_OFF;
            default: en_st_q <= EN_OFF;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Control and status registers
   // ----------------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         raw_q <= '0;
         mask_q <= `RST_INTR_MASK;
         cause_q <= 16'h0000;
         tx_tl_q <= `RST_THRESH;
         rx_threshold_field_q <= `RST_THRESH;
         en_q <= 1'b0;
      end
      else
      begin
         raw_q <= raw_d;
         if (wr_mask)
            mask_q <= i_reg_wdata;
         if (wr_tx_tl)
            tx_tl_q <= i_reg_wdata[7:0];
         if (wr_rx_threshold_field)
            rx_threshold_field_q <= i_reg_wdata[7:0];
         if (wr_en)
            en_q <= i_reg_wdata[`BIT_ENABLE];
         // Cause is captured with the abort, new cause wins a same-cycle clear
         if (i_tx_abort_evt)
            cause_q <= i_abort_cause;
         else if (rd_clr[`BIT_TX_ABORT] || rd_clr_all)
            cause_q <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------------
   // Transmit FIFO: held flushed while disabled or aborted
   // ----------------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         tx_wp_q <= '0;
         tx_rp_q <= '0;
         tx_cnt_q <= '0;
      end
      else if (tx_flush)
      begin
         tx_wp_q <= '0;
         tx_rp_q <= '0;
         tx_cnt_q <= '0;
      end
      else
      begin
         if (tx_push)
            tx_wp_q <= tx_wp_q + 1'b1;
         if (tx_pull)
            tx_rp_q <= tx_rp_q + 1'b1;
         tx_cnt_q <= tx_cnt_q + (AW+1)'(tx_push) - (AW+1)'(tx_pull);
      end
   end

   // Array write has no reset; only pointers bound what is valid
   always_ff @(posedge i_core_clk)
   begin
      if (tx_push)
         tx_mem[tx_wp_q] <= i_reg_wdata[8:0];
      if (rx_push)
         rx_mem[rx_wp_q] <= i_rx_byte;
   end

   // ----------------------------------------------------------------------
   // Receive FIFO: bytes beyond full are dropped
   // ----------------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rx_wp_q <= '0;
         rx_rp_q <= '0;
         rx_cnt_q <= '0;
      end
      else if (rx_flush)
      begin
         rx_wp_q <= '0;
         rx_rp_q <= '0;
         rx_cnt_q <= '0;
      end
      else
      begin
         if (rx_push)
            rx_wp_q <= rx_wp_q + 1'b1;
         if (rx_pull)
            rx_rp_q <= rx_rp_q + 1'b1;
         rx_cnt_q <= rx_cnt_q + (AW+1)'(rx_push) - (AW+1)'(rx_pull);
      end
   end

   // Next-cycle view of the FIFO, so the availability output is a flop
   wire [AW:0] tx_cnt_d = tx_flush ? '0 : tx_cnt_q + (AW+1)'(tx_push) - (AW+1)'(tx_pull);
   wire en_d = wr_en ? i_reg_wdata[`BIT_ENABLE] : en_q;
   wire tx_avail_d = (tx_cnt_d != '0) && en_d && !raw_d[`BIT_TX_ABORT];

   // ----------------------------------------------------------------------
   // Output flops
   // ----------------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
         irq_q <= 1'b0;
         tx_head_q <= 9'h000;
         scl_oe_n_q <= 1'b1;
         tx_avail_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         rvalid_q <= rd;
         irq_q <= |masked_word;
         tx_head_q <= tx_mem[tx_rp_q];
         // Stretch the clock while a read request waits for service
         scl_oe_n_q <= !raw_d[`BIT_RD_REQ];
         tx_avail_q <= tx_avail_d;
      end
   end

   assign o_reg_rdata = rdata_q;
   assign o_reg_rvalid = rvalid_q;
   assign o_scl_out = 1'b0;
   assign o_scl_oe_n = scl_oe_n_q;
   assign o_tx_head = tx_head_q;
   assign o_tx_avail = tx_avail_q;
   assign o_ctrl_enable = en_q;
   assign o_irq = irq_q;

endmodule

// >>> bench/i2c_intr_status_chk.sv
// Concurrent checks on the I2C interrupt status block's ports.
// Assumes the register map in the shared defines header.
`timescale 1ns/1ps
`include "i2c_intr_defines.svh"

module i2c_intr_status_chk (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Register port
   input wire logic i_reg_sel,
   input wire logic i_reg_write,
   input wire logic [31:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic [15:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   // Bus, engine and interrupt
   input wire logic o_scl_out,
   input wire logic o_scl_oe_n,
   input wire logic i_slv_tx_nack,
   input wire logic i_tx_abort_evt,
   input wire logic i_rd_req_evt,
   input wire logic o_tx_avail,
   input wire logic o_ctrl_enable,
   input wire logic o_irq
);
   logic [15:0] mask_q;
   logic clr_req_rd;

   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   // Mask shadow, so irq gating is judged from the ports alone
   assign clr_req_rd = i_reg_sel && !i_reg_write && i_reg_addr == `ADDR_CLR_RD_REQ;
   always_ff @(posedge i_core_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         mask_q <= `RST_INTR_MASK;
      else if (i_reg_sel && i_reg_write && i_reg_addr == `ADDR_INTR_MASK)
         mask_q <= i_reg_wdata;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   a_stretch_on_req: assert property (i_rd_req_evt && o_ctrl_enable |=> !o_scl_oe_n)
      else $error("clock line not held after read request");
   a_scl_drive_low: assert property (o_scl_out == 1'b0)
      else $error("stretch level is not low");
   a_stretch_release: assert property (clr_req_rd && !i_rd_req_evt |=> o_scl_oe_n)
      else $error("clock line still held after clear");
   a_clear_reads_zero: assert property (clr_req_rd |=> o_reg_rvalid && o_reg_rdata == 16'h0)
      else $error("clear register read gave data");
   a_nack_irq_path: assert property (i_slv_tx_nack && o_ctrl_enable && mask_q[7] |=> ##1 o_irq)
      else $error("transmit done did not raise irq");
   a_abort_irq_path: assert property (i_tx_abort_evt && o_ctrl_enable && mask_q[6] |=> ##1 o_irq)
      else $error("abort did not raise irq");
   a_abort_flushes_tx: assert property (i_tx_abort_evt && o_ctrl_enable |=> !o_tx_avail [*2])
      else $error("transmit data offered after abort");
   a_disabled_no_tx: assert property (!o_ctrl_enable && !$past(o_ctrl_enable) |-> !o_tx_avail)
      else $error("transmit data offered while disabled");
   a_mask_gates_irq: assert property (mask_q == 16'h0 |=> !o_irq)
      else $error("irq with every source masked");
endmodule

bind i2c_interrupt_status_logic i2c_intr_status_chk chk (
   .i_core_clk(i_core_clk),
   .i_sys_rst(i_sys_rst),
   .i_reg_sel(i_reg_sel),
   .i_reg_write(i_reg_write),
   .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata),
   .o_reg_rvalid(o_reg_rvalid),
   .o_scl_out(o_scl_out),
   .o_scl_oe_n(o_scl_oe_n),
   .i_slv_tx_nack(i_slv_tx_nack),
   .i_tx_abort_evt(i_tx_abort_evt),
   .i_rd_req_evt(i_rd_req_evt),
   .o_tx_avail(o_tx_avail),
   .o_ctrl_enable(o_ctrl_enable),
   .o_irq(o_irq)
);

// >>> bench/i2c_remote_master.sv
// Remote bus master model: frames START and STOP on the two lines.
// Assumes the bench wires SCL open-drain with the device's pull-down.
`timescale 1ns/1ps

module i2c_remote_master (
   // Wired clock line as seen on the bus
   input wire logic i_scl_line,
   // Lines driven, high means released to the pull-up
   output logic o_scl,
   output logic o_sda,
   output logic o_done
);
   // Idle bus: both lines released, clock stands still
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
      o_done = 1'b0;
   end
   // START: data falls while the clock stands high
   task automatic start_cond();
      #3 o_sda = 1'b0;
      #80 o_scl = 1'b0;
      #80;
   endtask
   // STOP: release clock, wait out any stretch (bounded), release data
   task automatic stop_cond();
      int k;
      o_done = 1'b0;
      #80 o_scl = 1'b1;
      for (k = 0; k < 400 && i_scl_line !== 1'b1; k++) #20;
      #80 o_sda = 1'b1;
      o_done = 1'b1;
   endtask
endmodule

// >>> bench/i2c_interrupt_status_logic_bench.sv
// Self-checking bench for the I2C interrupt status block.
// Assumes the defines header, checker and remote master model are compiled.
`timescale 1ns/1ps
`include "i2c_intr_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module i2c_interrupt_status_logic_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sel = 1'b0, wen = 1'b0, rvalid, scl_out, oe_n, tx_avail, ctrl_en, irq;
   logic [31:0] addr = 32'h0;
   logic [15:0] wdata = 16'h0, rdata, d, cause = 16'h0;
   logic p_scl, p_sda, p_done, scl_line, eng = 1'b0;
   logic pop = 1'b0, nack = 1'b0, abrt = 1'b0, rdreq = 1'b0, rxv = 1'b0;
   logic [7:0] rxb = 8'h0;
   logic [8:0] tx_head;
   int failures = 0, n_tests = 0, k;

   // Open-drain clock: either party may pull it low
   assign scl_line = p_scl & (oe_n | scl_out);
   always #10 clk = ~clk;

   i2c_interrupt_status_logic uut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_sel(sel),
      .i_reg_write(wen), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .o_reg_rvalid(rvalid), .i_scl(scl_line), .i_sda(p_sda), .o_scl_out(scl_out),
      .o_scl_oe_n(oe_n), .i_engine_active(eng), .i_slv_tx_nack(nack),
      .i_tx_abort_evt(abrt), .i_abort_cause(cause), .i_rd_req_evt(rdreq),
      .i_rx_valid(rxv), .i_rx_byte(rxb), .i_tx_pop(pop), .o_tx_head(tx_head),
      .o_tx_avail(tx_avail), .o_ctrl_enable(ctrl_en), .o_irq(irq));
   i2c_remote_master peer (.i_scl_line(scl_line), .o_scl(p_scl), .o_sda(p_sda),
      .o_done(p_done));

   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] v);
      @(posedge clk);
      sel <= 1'b1;
      wen <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      sel <= 1'b0;
   endtask
   // Read waits a bounded time for the registered answer
   task automatic rd(input logic [31:0] a, output logic [15:0] v);
      int n;
      @(posedge clk);
      sel <= 1'b1;
      wen <= 1'b0;
      addr <= a;
      @(posedge clk);
      sel <= 1'b0;
      @(negedge clk);
      for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk);
      if (n == 4)
      begin
         failures++;
         complete_run();
      end
      else
         v = rdata;
   endtask
   task automatic chkr(input logic [31:0] a, input logic [15:0] m, input logic [15:0] e);
      rd(a, d);
      `CHK(d & m, e)
   endtask
   // One-cycle engine pulses: {pop, nack, abort, read request, rx valid}
   task automatic ev(input logic [4:0] m);
      @(posedge clk);
      {pop, nack, abrt, rdreq, rxv} <= m;
      @(posedge clk);
      {pop, nack, abrt, rdreq, rxv} <= 5'h0;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chkr(`ADDR_INTR_MASK, 16'hffff, 16'h08ff);
      chkr(`ADDR_RAW_STAT, 16'hffff, 16'h0000);
      chkr(32'h50001300, 16'hffff, 16'h0000);
      wr(`ADDR_MASKED_STAT, 16'hffff);
      chkr(`ADDR_MASKED_STAT, 16'hffff, 16'h0000);
      wr(`ADDR_CTRL_ENABLE, 16'h0001);
      wr(`ADDR_RX_THRESH, 16'h0001);
      chkr(`ADDR_RAW_STAT, 16'h07ff, 16'h0010);
      `CHK(irq, 1'b1)
      wr(`ADDR_INTR_MASK, 16'h0000);
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK(irq, 1'b0)
      chkr(`ADDR_MASKED_STAT, 16'hffff, 16'h0000);
      wr(`ADDR_INTR_MASK, 16'h08ff);
      for (k = 0; k < 33; k++) wr(`ADDR_DATA_CMD, 16'h0100 + k[15:0]);
      chkr(`ADDR_RAW_STAT, 16'h0018, 16'h0008);
      `CHK(tx_head, 9'h100)
      ev(5'h10);
      rd(`ADDR_CLR_TX_OVER, d);
      wr(`ADDR_TX_THRESH, 16'h001f);
      chkr(`ADDR_RAW_STAT, 16'h0018, 16'h0010);
      cause <= 16'h00a5;
      ev(5'h04);
      chkr(`ADDR_RAW_STAT, 16'h0040, 16'h0040);
      `CHK(tx_avail, 1'b0)
      wr(`ADDR_DATA_CMD, 16'h0011);
      `CHK(tx_avail, 1'b0)
      chkr(`ADDR_ABORT_CAUSE, 16'hffff, 16'h00a5);
      rd(`ADDR_CLR_TX_ABORT, d);
      chkr(`ADDR_RAW_STAT, 16'h0040, 16'h0000);
      wr(`ADDR_DATA_CMD, 16'h0055);
      @(negedge clk);
      `CHK(tx_avail, 1'b1)
      ev(5'h08);
      chkr(`ADDR_RAW_STAT, 16'h0080, 16'h0080);
      rd(`ADDR_CLR_TX_DONE, d);
      rd(`ADDR_DATA_CMD, d);
      chkr(`ADDR_RAW_STAT, 16'h0001, 16'h0001);
      for (k = 0; k < 33; k++)
      begin
         rxb <= 8'h40 + k[7:0];
         ev(5'h01);
      end
      chkr(`ADDR_RAW_STAT, 16'h0007, 16'h0007);
      chkr(`ADDR_DATA_CMD, 16'h00ff, 16'h0040);
      peer.start_cond();
      repeat (8) @(posedge clk);
      chkr(`ADDR_RAW_STAT, 16'h0700, 16'h0500);
      ev(5'h02);
      @(negedge clk);
      `CHK(scl_line, 1'b0)
      chkr(`ADDR_RAW_STAT, 16'h0020, 16'h0020);
      fork
         peer.stop_cond();
      join_none
      wr(`ADDR_DATA_CMD, 16'h0033);
      rd(`ADDR_CLR_RD_REQ, d);
      `CHK(oe_n, 1'b1)
      chkr(`ADDR_RAW_STAT, 16'h0020, 16'h0000);
      for (k = 0; k < 200 && p_done !== 1'b1; k++) @(posedge clk);
      repeat (8) @(posedge clk);
      chkr(`ADDR_RAW_STAT, 16'h0300, 16'h0300);
      rd(`ADDR_CLR_ACTIVITY, d);
      chkr(`ADDR_RAW_STAT, 16'h0100, 16'h0000);
      eng <= 1'b1;
      wr(`ADDR_CTRL_ENABLE, 16'h0000);
      chkr(`ADDR_RAW_STAT, 16'h0117, 16'h0013);
      eng <= 1'b0;
      repeat (4) @(posedge clk);
      chkr(`ADDR_RAW_STAT, 16'hffff, 16'h0000);
      `CHK(tx_avail, 1'b0)
      complete_run();
   end
endmodule
